//--- design/ccr_counter_routing.sv
`timescale 1ns/100ps
// Summary of operation
// - Counter one clock: time base or input one
// - Counter two clock: time base or input three
// - Time base select: 100k, 10k, 1k, 100 Hz
// - Counters advance only while gate enabled
// - Counter one gate: software bit or input zero
// - Counter two gate: software bit or input two
// - Counter one output optionally drives output two
// - Counter two output optionally drives output three
// - Flag reads one when interrupt pending
// - Writing one clears flag, zero ignored
// - Interrupt only when enable set, reset disabled
// - Cascade bit joins counters into 32 bits
// - Two independent 16-bit down counters
// - Load values accepted from 2 to 65535
// - Control written, status read back
module ccr_counter_routing
#(
  parameter int unsigned TB_DIV_100K = ccr_pkg::TB_DIV_100K,
  parameter int unsigned TB_DIV_10K  = ccr_pkg::TB_DIV_10K,
  parameter int unsigned TB_DIV_1K   = ccr_pkg::TB_DIV_1K,
  parameter int unsigned TB_DIV_100  = ccr_pkg::TB_DIV_100
)
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_first_counter_clock_select,
  input  wire logic        i_second_counter_clock_select,
  input  wire logic        i_timebase_select_low,
  input  wire logic        i_timebase_select_high,
  input  wire logic        i_first_counter_gate_select,
  input  wire logic        i_second_counter_gate_select,
  input  wire logic        i_first_counter_software_gate,
  input  wire logic        i_second_counter_software_gate,
  input  wire logic        i_first_counter_output_route,
  input  wire logic        i_second_counter_output_route,
  input  wire logic        i_first_counter_irq_enable,
  input  wire logic        i_second_counter_irq_enable,
  input  wire logic        i_cascade_enable,
  input  wire logic        i_first_counter_irq_clear,
  input  wire logic        i_second_counter_irq_clear,
  input  wire logic        i_first_counter_load,
  input  wire logic [15:0] i_first_counter_load_value,
  input  wire logic        i_second_counter_load,
  input  wire logic [15:0] i_second_counter_load_value,
  input  wire logic        i_iso_input_zero,
  input  wire logic        i_iso_input_one,
  input  wire logic        i_iso_input_two,
  input  wire logic        i_iso_input_three,
  output logic             o_iso_output_two,
  output logic             o_iso_output_three,
  output logic             o_first_counter_output_status,
  output logic             o_second_counter_output_status,
  output logic             o_first_counter_irq_flag,
  output logic             o_second_counter_irq_flag,
  output logic             o_first_counter_irq,
  output logic             o_second_counter_irq,
  output logic      [15:0] o_first_counter_value,
  output logic      [15:0] o_second_counter_value
);

  localparam int unsigned TW = ccr_pkg::TB_CNT_W;

  ////////////////////////////////////////////////////////////////////////////
  // Time base divider
  ccr_pkg::ccr_tb_sel_t tb_sel;
  logic [TW-1:0]        tb_last;
  logic [TW-1:0]        tb_cnt_r;
  logic [TW-1:0]        tb_cnt_nxt;
  logic                 tb_tick_r;
  logic                 tb_tick_nxt;

  assign tb_sel = ccr_pkg::ccr_tb_sel_t'({i_timebase_select_high, i_timebase_select_low});

  always_comb
  begin
    case (tb_sel)
      ccr_pkg::CCR_TB_100K: tb_last = TW'(TB_DIV_100K - 1);
      ccr_pkg::CCR_TB_10K:  tb_last = TW'(TB_DIV_10K - 1);
      ccr_pkg::CCR_TB_1K:   tb_last = TW'(TB_DIV_1K - 1);
      ccr_pkg::CCR_TB_100:  tb_last = TW'(TB_DIV_100 - 1);
      default:              tb_last = TW'(TB_DIV_100K - 1);
    endcase
  end

  always_comb
  begin
    tb_tick_nxt = 1'b0;
    // A shortened period after a rate change restarts cleanly
    if (tb_cnt_r >= tb_last)
    begin
      tb_cnt_nxt  = ccr_pkg::TB_CNT_RST;
      tb_tick_nxt = 1'b1;
    end
    else
    begin
      tb_cnt_nxt = tb_cnt_r + TW'(1);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      tb_cnt_r  <= ccr_pkg::TB_CNT_RST;
      tb_tick_r <= 1'b0;
    end
    else
    begin
      tb_cnt_r  <= tb_cnt_nxt;
      tb_tick_r <= tb_tick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External clock edge detection
  logic ext1_d_r;
  logic ext3_d_r;
  logic ext1_rise;
  logic ext3_rise;

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ext1_d_r <= 1'b0;
      ext3_d_r <= 1'b0;
    end
    else
    begin
      ext1_d_r <= i_iso_input_one;
      ext3_d_r <= i_iso_input_three;
    end
  end

  assign ext1_rise = i_iso_input_one && !ext1_d_r;
  assign ext3_rise = i_iso_input_three && !ext3_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and gate routing
  logic c0_tick;
  logic c1_tick;
  logic c0_gate;
  logic c1_gate;
  logic c0_pulse;
  logic c1_pulse;

  always_comb
  begin
    if (i_first_counter_clock_select == ccr_pkg::CLK_SEL_INTERNAL)
    begin
      c0_tick = tb_tick_r;
    end
    else
    begin
      c0_tick = ext1_rise;
    end
    if (i_cascade_enable)
    begin
      c1_tick = c0_pulse;
    end
    else if (i_second_counter_clock_select == ccr_pkg::CLK_SEL_INTERNAL)
    begin
      c1_tick = tb_tick_r;
    end
    else
    begin
      c1_tick = ext3_rise;
    end
  end

  always_comb
  begin
    if (i_first_counter_gate_select == ccr_pkg::GATE_SEL_SOFT)
    begin
      c0_gate = i_first_counter_software_gate;
    end
    else
    begin
      c0_gate = i_iso_input_zero;
    end
    if (i_second_counter_gate_select == ccr_pkg::GATE_SEL_SOFT)
    begin
      c1_gate = i_second_counter_software_gate;
    end
    else
    begin
      c1_gate = i_iso_input_two;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter cores
  logic [15:0] c0_count;
  logic [15:0] c1_count;

  ccr_down_counter u_first_counter
  (
    .i_sys_clk    (i_sys_clk),
    .i_arst_n     (i_arst_n),
    .i_tick       (c0_tick),
    .i_gate       (c0_gate),
    .i_load       (i_first_counter_load),
    .i_load_value (i_first_counter_load_value),
    .o_count      (c0_count),
    .o_pulse      (c0_pulse)
  );

  ccr_down_counter u_second_counter
  (
    .i_sys_clk    (i_sys_clk),
    .i_arst_n     (i_arst_n),
    .i_tick       (c1_tick),
    .i_gate       (c1_gate),
    .i_load       (i_second_counter_load),
    .i_load_value (i_second_counter_load_value),
    .o_count      (c1_count),
    .o_pulse      (c1_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output routing, interrupt flags and status
  logic        c0_irq_out;
  logic        stat0_r;
  logic        stat0_nxt;
  logic        stat1_r;
  logic        stat1_nxt;
  logic        do2_r;
  logic        do2_nxt;
  logic        do3_r;
  logic        do3_nxt;
  logic        flag0_r;
  logic        flag0_nxt;
  logic        flag1_r;
  logic        flag1_nxt;
  logic        irq0_r;
  logic        irq0_nxt;
  logic        irq1_r;
  logic        irq1_nxt;
  logic [15:0] val0_r;
  logic [15:0] val1_r;

  // In cascade mode only the combined terminal event raises an interrupt
  assign c0_irq_out = c0_pulse && !i_cascade_enable;

  always_comb
  begin
    stat0_nxt = c0_pulse;
    stat1_nxt = c1_pulse;
    do2_nxt   = c0_pulse && i_first_counter_output_route;
    do3_nxt   = c1_pulse && i_second_counter_output_route;
    // Set wins over a clear in the same cycle
    flag0_nxt = flag0_r;
    if (i_first_counter_irq_clear)
    begin
      flag0_nxt = 1'b0;
    end
    if (c0_irq_out && i_first_counter_irq_enable)
    begin
      flag0_nxt = 1'b1;
    end
    flag1_nxt = flag1_r;
    if (i_second_counter_irq_clear)
    begin
      flag1_nxt = 1'b0;
    end
    if (c1_pulse && i_second_counter_irq_enable)
    begin
      flag1_nxt = 1'b1;
    end
    irq0_nxt = flag0_nxt && i_first_counter_irq_enable;
    irq1_nxt = flag1_nxt && i_second_counter_irq_enable;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      stat0_r <= 1'b0;
      stat1_r <= 1'b0;
      do2_r   <= 1'b0;
      do3_r   <= 1'b0;
      flag0_r <= 1'b0;
      flag1_r <= 1'b0;
      irq0_r  <= 1'b0;
      irq1_r  <= 1'b0;
      val0_r  <= ccr_pkg::CNT_RST_VALUE;
      val1_r  <= ccr_pkg::CNT_RST_VALUE;
    end
    else
    begin
      stat0_r <= stat0_nxt;
      stat1_r <= stat1_nxt;
      do2_r   <= do2_nxt;
      do3_r   <= do3_nxt;
      flag0_r <= flag0_nxt;
      flag1_r <= flag1_nxt;
      irq0_r  <= irq0_nxt;
      irq1_r  <= irq1_nxt;
      val0_r  <= c0_count;
      val1_r  <= c1_count;
    end
  end

  assign o_first_counter_output_status  = stat0_r;
  assign o_second_counter_output_status = stat1_r;
  assign o_iso_output_two               = do2_r;
  assign o_iso_output_three             = do3_r;
  assign o_first_counter_irq_flag       = flag0_r;
  assign o_second_counter_irq_flag      = flag1_r;
  assign o_first_counter_irq            = irq0_r;
  assign o_second_counter_irq           = irq1_r;
  assign o_first_counter_value          = val0_r;
  assign o_second_counter_value         = val1_r;

endmodule : ccr_counter_routing

//--- design/ccr_pkg.sv
package ccr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // System clock
  localparam int unsigned SYS_CLK_HZ = 250_000_000;

  ////////////////////////////////////////////////////////////////////////////
  // Internal time base rates, in hertz
  localparam int unsigned TB_HZ_100K = 100_000;
  localparam int unsigned TB_HZ_10K  = 10_000;
  localparam int unsigned TB_HZ_1K   = 1_000;
  localparam int unsigned TB_HZ_100  = 100;

  // Cycles of the system clock per time base period
  localparam int unsigned TB_DIV_100K = SYS_CLK_HZ / TB_HZ_100K;
  localparam int unsigned TB_DIV_10K  = SYS_CLK_HZ / TB_HZ_10K;
  localparam int unsigned TB_DIV_1K   = SYS_CLK_HZ / TB_HZ_1K;
  localparam int unsigned TB_DIV_100  = SYS_CLK_HZ / TB_HZ_100;

  localparam int unsigned TB_CNT_W = 24;

  ////////////////////////////////////////////////////////////////////////////
  // Time base select encoding {high, low}
  typedef enum logic [1:0] {
    CCR_TB_100K = 2'h0,
    CCR_TB_10K  = 2'h1,
    CCR_TB_1K   = 2'h2,
    CCR_TB_100  = 2'h3
  } ccr_tb_sel_t;

  ////////////////////////////////////////////////////////////////////////////
  // Counter core
  localparam int unsigned CNT_W = 16;
  localparam logic [15:0] CNT_MIN_LOAD  = 16'h0002;
  localparam logic [15:0] CNT_RST_VALUE = 16'hffff;
  localparam logic [15:0] CNT_ONE       = 16'h0001;

  // Select bit meanings
  localparam logic CLK_SEL_INTERNAL = 1'b0;
  localparam logic GATE_SEL_SOFT    = 1'b0;

  // Reset values of control state
  localparam logic [23:0] TB_CNT_RST = 24'h000000;

endpackage : ccr_pkg

//--- design/ccr_down_counter.sv
`timescale 1ns/100ps
module ccr_down_counter
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_tick,
  input  wire logic        i_gate,
  input  wire logic        i_load,
  input  wire logic [15:0] i_load_value,
  output logic      [15:0] o_count,
  output logic             o_pulse
);

  logic [15:0] reload_r;
  logic [15:0] reload_nxt;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic        pulse_r;
  logic        pulse_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Count, reload and terminal pulse
  always_comb
  begin
    reload_nxt = reload_r;
    count_nxt  = count_r;
    pulse_nxt  = 1'b0;
    if (i_load)
    begin
      // Values below the minimum are raised to it
      if (i_load_value < ccr_pkg::CNT_MIN_LOAD)
      begin
        reload_nxt = ccr_pkg::CNT_MIN_LOAD;
      end
      else
      begin
        reload_nxt = i_load_value;
      end
      count_nxt = reload_nxt;
    end
    else if (i_tick && i_gate)
    begin
      if (count_r <= ccr_pkg::CNT_ONE)
      begin
        count_nxt = reload_r;
        pulse_nxt = 1'b1;
      end
      else
      begin
        count_nxt = count_r - ccr_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      reload_r <= ccr_pkg::CNT_RST_VALUE;
      count_r  <= ccr_pkg::CNT_RST_VALUE;
      pulse_r  <= 1'b0;
    end
    else
    begin
      reload_r <= reload_nxt;
      count_r  <= count_nxt;
      pulse_r  <= pulse_nxt;
    end
  end

  assign o_count = count_r;
  assign o_pulse = pulse_r;

endmodule : ccr_down_counter

//--- testbench/ccr_checker.sv
`timescale 1ns/100ps
module ccr_checker
(
  input wire logic        i_sys_clk, i_arst_n, i_cascade_enable,
  input wire logic        i_first_counter_gate_select, i_first_counter_software_gate,
  input wire logic        i_first_counter_load, i_first_counter_irq_enable,
  input wire logic        i_first_counter_irq_clear, i_first_counter_output_route,
  input wire logic        i_second_counter_output_route,
  input wire logic [15:0] i_first_counter_load_value,
  input wire logic        o_iso_output_two, o_iso_output_three,
  input wire logic        o_first_counter_output_status, o_second_counter_output_status,
  input wire logic        o_first_counter_irq_flag, o_first_counter_irq,
  input wire logic [15:0] o_first_counter_value
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_arst_n);

  sequence s_gate_shut;
    !i_first_counter_gate_select && !i_first_counter_software_gate && !i_first_counter_load;
  endsequence

  a_iso_two_route:
    assert property (o_iso_output_two == (o_first_counter_output_status &&
      $past(i_first_counter_output_route))) else $error("iso two wrong");
  a_iso_three_route:
    assert property (o_iso_output_three == (o_second_counter_output_status &&
      $past(i_second_counter_output_route))) else $error("iso three wrong");
  a_irq_follows_flag:
    assert property (o_first_counter_irq == (o_first_counter_irq_flag &&
      $past(i_first_counter_irq_enable))) else $error("irq wrong");
  a_flag_set_cause:
    assert property ($rose(o_first_counter_irq_flag) |-> o_first_counter_output_status &&
      $past(i_first_counter_irq_enable) && !$past(i_cascade_enable)) else $error("flag set");
  a_flag_clears:
    assert property (i_first_counter_irq_clear |=> !o_first_counter_irq_flag ||
      o_first_counter_output_status) else $error("flag not cleared");
  a_flag_held:
    assert property (o_first_counter_irq_flag && !i_first_counter_irq_clear |=>
      o_first_counter_irq_flag) else $error("flag dropped");
  a_gate_blocks_count:
    assert property (s_gate_shut |-> ##2 $stable(o_first_counter_value))
      else $error("count moved");
  a_load_taken:
    assert property (i_first_counter_load && i_first_counter_load_value > 16'h0001 |->
      ##2 o_first_counter_value == $past(i_first_counter_load_value, 2))
      else $error("load wrong");
endmodule : ccr_checker

bind ccr_counter_routing ccr_checker ccr_checker_i (.*);

//--- testbench/ccr_iso_model.sv
`timescale 1ns/100ps
module ccr_iso_model
(
  input  wire logic i_sys_clk,
  input  wire logic i_burst,
  input  wire logic i_gate_zero,
  input  wire logic i_gate_two,
  input  wire logic i_out_two,
  input  wire logic i_out_three,
  output logic      o_in_zero,
  output logic      o_in_one,
  output logic      o_in_two,
  output logic      o_in_three,
  output int        o_seen_two,
  output int        o_seen_three
);
  int n = 0;
  initial {o_in_one, o_in_three, o_seen_two, o_seen_three} = '0;
  assign o_in_zero = i_gate_zero;
  assign o_in_two  = i_gate_two;
  // Four edges on input one, three on input three
  always @(posedge i_sys_clk)
  begin
    n <= i_burst ? 8 : (n > 0 ? n - 1 : 0);
    o_in_one <= n[0];
    o_in_three <= n[0] && n > 2;
    o_seen_two <= o_seen_two + int'(i_out_two);
    o_seen_three <= o_seen_three + int'(i_out_three);
  end
endmodule : ccr_iso_model

//--- testbench/ccr_counter_routing_test.sv
`timescale 1ns/100ps
module ccr_counter_routing_test;
  logic i_sys_clk = '0, i_arst_n = '0, i_first_counter_clock_select = '0;
  logic i_second_counter_clock_select = '0, i_timebase_select_low = '0;
  logic i_timebase_select_high = '0, i_first_counter_gate_select = '0;
  logic i_second_counter_gate_select = '0, i_first_counter_software_gate = '0;
  logic i_second_counter_software_gate = '0, i_first_counter_output_route = '0;
  logic i_second_counter_output_route = '0, i_first_counter_irq_enable = '0;
  logic i_second_counter_irq_enable = '0, i_cascade_enable = '0;
  logic i_first_counter_irq_clear = '0, i_second_counter_irq_clear = '0;
  logic i_first_counter_load = '0, i_second_counter_load = '0;
  logic [15:0] i_first_counter_load_value = '0, i_second_counter_load_value = '0;
  logic i_iso_input_zero, i_iso_input_one, i_iso_input_two, i_iso_input_three;
  logic o_iso_output_two, o_iso_output_three, o_first_counter_irq, o_second_counter_irq;
  logic o_first_counter_output_status, o_second_counter_output_status;
  logic o_first_counter_irq_flag, o_second_counter_irq_flag;
  logic [15:0] o_first_counter_value, o_second_counter_value;
  logic burst = '0, gz = '0, g2 = '0;
  int seen_two, seen_three, err_total = 0, comparisons = 0, cyc = 0, s2, s3, t;
  int div[4] = '{8, 16, 32, 64};

  ccr_counter_routing #(.TB_DIV_100K(8), .TB_DIV_10K(16), .TB_DIV_1K(32), .TB_DIV_100(64))
    ccr_counter_routing_i (.*);
  ccr_iso_model ccr_iso_model_i (.i_sys_clk(i_sys_clk), .i_burst(burst), .i_gate_zero(gz),
    .i_gate_two(g2), .i_out_two(o_iso_output_two), .i_out_three(o_iso_output_three),
    .o_in_zero(i_iso_input_zero), .o_in_one(i_iso_input_one), .o_in_two(i_iso_input_two),
    .o_in_three(i_iso_input_three), .o_seen_two(seen_two), .o_seen_three(seen_three));

  always #2 i_sys_clk = ~i_sys_clk;

  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task complete_run;
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  always @(posedge i_sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      complete_run();
    end
  end

  task wt(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask : wt

  task ext_clocks;
    @(posedge i_sys_clk);
    {i_first_counter_clock_select, i_second_counter_clock_select} <= 2'h3;
    {i_first_counter_gate_select, i_second_counter_gate_select, gz, g2} <= 4'hf;
    {i_first_counter_output_route, i_first_counter_irq_enable} <= 2'h3;
    i_second_counter_output_route <= 1'b1;
    {i_first_counter_load, i_second_counter_load} <= 2'h3;
    i_first_counter_load_value <= 16'h0002;
    i_second_counter_load_value <= 16'h0002;
    @(posedge i_sys_clk);
    {i_first_counter_load, i_second_counter_load, burst} <= 3'h1;
    s2 = seen_two;
    s3 = seen_three;
    @(posedge i_sys_clk);
    burst <= 1'b0;
    wt(24);
    chk("iso two pulses", 16'(seen_two - s2), 16'h0002);
    chk("iso three pulses", 16'(seen_three - s3), 16'h0001);
    chk("second count", o_second_counter_value, 16'h0001);
    chk("flag one", 16'(o_first_counter_irq_flag), 16'h0001);
    chk("irq one", 16'(o_first_counter_irq), 16'h0001);
    chk("flag two", 16'(o_second_counter_irq_flag), 16'h0000);
    @(posedge i_sys_clk);
    {i_first_counter_irq_clear, gz, burst} <= 3'h5;
    s2 = seen_two;
    @(posedge i_sys_clk);
    {i_first_counter_irq_clear, burst} <= 2'h0;
    wt(24);
    chk("flag cleared", 16'(o_first_counter_irq_flag), 16'h0000);
    chk("gated pulses", 16'(seen_two - s2), 16'h0000);
    @(posedge i_sys_clk);
    {i_first_counter_clock_select, i_first_counter_gate_select} <= 2'h0;
  endtask : ext_clocks

  task time_base;
    for (int c = 0; c < 4; c++)
    begin
      @(posedge i_sys_clk);
      {i_timebase_select_high, i_timebase_select_low} <= 2'(c);
      {i_first_counter_software_gate, i_first_counter_load} <= 2'h3;
      @(posedge i_sys_clk);
      i_first_counter_load <= 1'b0;
      repeat (2)
      begin
        t = 0;
        do
        begin
          wt(1);
          t++;
        end while (o_first_counter_output_status !== 1'b1 && t < 1000);
      end
      chk("pulse period", 16'(t), 16'(2 * div[c]));
    end
  endtask : time_base

  task cascade;
    @(posedge i_sys_clk);
    {i_timebase_select_high, i_timebase_select_low, i_second_counter_clock_select} <= 3'h0;
    {i_cascade_enable, i_second_counter_irq_enable, i_second_counter_gate_select} <= 3'h6;
    {i_second_counter_software_gate, i_first_counter_load, i_second_counter_load} <= 3'h7;
    i_first_counter_irq_clear <= 1'b1;
    @(posedge i_sys_clk);
    {i_first_counter_load, i_second_counter_load} <= 2'h0;
    wt(3);
    @(posedge i_sys_clk);
    i_first_counter_irq_clear <= 1'b0;
    wt(70);
    chk("cascade flag two", 16'(o_second_counter_irq_flag), 16'h0001);
    chk("cascade flag one", 16'(o_first_counter_irq_flag), 16'h0000);
    chk("cascade irq two", 16'(o_second_counter_irq), 16'h0001);
  endtask : cascade

  initial
  begin
    repeat (5) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    wt(2);
    chk("reset flag", 16'(o_first_counter_irq_flag), 16'h0000);
    chk("reset irq", 16'(o_second_counter_irq), 16'h0000);
    ext_clocks();
    time_base();
    cascade();
    complete_run();
  end
endmodule : ccr_counter_routing_test
